/* test_timer0_wide_access_capture_ctrl.sv */
// Bench for the timer and its processor end joined by the byte bus.
// Assumes byte commands at AXI offset zero and readback at eight.
`timescale 1ns/100ps
module test_timer0_wide_access_capture_ctrl
   import tmrw_pkg::*;
;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic tick = 1'h0, pin = 1'h0, cmpo = 1'h0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] exp_q[$];
   logic [31:0] seed = 32'h41D6;
   int fail_count = 0;
   int compares = 0;
   always #4 aclk = ~aclk;
   tmrw_if ifc (.aclk(aclk));
   tmrw_timer tmrw_timer_i (.aclk(aclk), .aresetn(aresetn), .bus(ifc.dev), .timer_tick_enable(tick),
      .capture_pin(pin), .comparator_out(cmpo));
   tmrw_cpu tmrw_cpu_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .bus(ifc.cpu));
   tmrw_props tmrw_props_i (.aclk(aclk), .aresetn(aresetn), .addr(ifc.addr), .wdata(ifc.wdata), .wr(ifc.wr),
      .rd(ifc.rd), .rdata(ifc.rdata), .irq(ifc.irq));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic report_and_stop();
      $display("Compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic hang(input logic got);
      if (!got) begin
         fail_count++;
         $display("[FAIL] %0t no answer", $time);
         report_and_stop();
      end
   endtask : hang
   ////////////////////////////////////////////////////////////////////////////////
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic got;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         got = bvalid;
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!got && n < 64);
      bready <= 1'h0;
      hang(got);
      chk({30'h0, bresp}, {30'h0, er});
      // One idle edge so the next call never re-raises in this step
      @(posedge aclk);
   endtask : axi_wr
   task automatic axi_rd(input logic [31:0] a, input logic [31:0] e);
      int n;
      logic got;
      n = 0;
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         got = rvalid;
         if (arready) arvalid <= 1'h0;
      end while (!got && n < 64);
      rready <= 1'h0;
      hang(got);
      @(posedge aclk);
   endtask : axi_rd
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         if (exp_q.size() == 0) chk(rdata, 32'hFFFFFFFF);
         else chk(rdata, exp_q.pop_front());
         chk({30'h0, rresp}, 32'h0);
      end
   end
   task automatic bwr(input logic [5:0] a, input logic [7:0] d);
      axi_wr(TMRW_AXI_ADDR_OFF, {16'h0000, 2'h0, a, d}, 2'h0);
   endtask : bwr
   task automatic brd(input logic [5:0] a, input logic [7:0] e);
      axi_wr(TMRW_AXI_ADDR_OFF, {16'h0000, 2'h2, a, 8'h00}, 2'h0);
      repeat (2) @(posedge aclk);
      axi_rd(TMRW_AXI_ADDR_RDATA, {24'h000000, e});
   endtask : brd
   task automatic ticks(input int n);
      tick <= 1'h1;
      repeat (n) @(posedge aclk);
      tick <= 1'h0;
   endtask : ticks
   // s goes to the selected capture source, u to the other one
   task automatic srcs(input logic r, input logic s, input logic u, input int n);
      pin <= r ? u : s;
      cmpo <= r ? s : u;
      repeat (n) @(posedge aclk);
   endtask : srcs
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] v;
      logic e, f, r, w;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      brd(TMRW_ADDR_CTRL, 8'h00);
      axi_wr(32'h0000_000C, 32'h0000_8000, 2'h2);
      bwr(TMRW_ADDR_CTRL, 8'hFF);
      brd(TMRW_ADDR_CTRL, 8'hF9);
      bwr(TMRW_ADDR_CTRL, 8'h80);
      v = 16'(rnd());
      bwr(TMRW_ADDR_CNT_H, v[15:8]);
      brd(TMRW_ADDR_CNT_H, v[15:8]);
      bwr(TMRW_ADDR_CMP_A, 8'h5A);
      bwr(TMRW_ADDR_CNT_L, v[7:0]);
      brd(TMRW_ADDR_CMP_B, v[15:8]);
      brd(TMRW_ADDR_CMP_A, 8'h5A);
      bwr(TMRW_ADDR_CNT_H, ~v[15:8]);
      brd(TMRW_ADDR_CNT_L, v[7:0]);
      brd(TMRW_ADDR_CMP_A, 8'h5A);
      brd(TMRW_ADDR_CNT_H, v[15:8]);
      $display("Wide access done");
      bwr(TMRW_ADDR_CNT_H, 8'h00);
      bwr(TMRW_ADDR_CNT_L, 8'hFF);
      ticks(5);
      brd(TMRW_ADDR_CNT_L, 8'h04);
      brd(TMRW_ADDR_CNT_H, 8'h01);
      bwr(TMRW_ADDR_CTRL, 8'h01);
      bwr(TMRW_ADDR_CMP_A, 8'h03);
      bwr(TMRW_ADDR_CNT_L, 8'h00);
      ticks(10);
      brd(TMRW_ADDR_CNT_L, 8'h02);
      bwr(TMRW_ADDR_CTRL, 8'h81);
      bwr(TMRW_ADDR_CNT_H, 8'h00);
      bwr(TMRW_ADDR_CNT_L, 8'h00);
      ticks(10);
      brd(TMRW_ADDR_CNT_L, 8'h0A);
      $display("Counting done");
      for (int k = 0; k < 16; k++) begin
         {w, r, f, e} = 4'(k);
         bwr(TMRW_ADDR_CTRL, 8'h80);
         v = 16'(rnd());
         bwr(TMRW_ADDR_CNT_H, v[15:8]);
         bwr(TMRW_ADDR_CNT_L, v[7:0]);
         // Seed pair so both widths read back the same high byte
         bwr(TMRW_ADDR_CMP_A, 8'h00);
         srcs(r, e, e, 12);
         bwr(TMRW_ADDR_CTRL, {w, 1'h1, f, e, r, 3'h0});
         bwr(TMRW_ADDR_FLAG, 8'h01);
         bwr(TMRW_ADDR_MASK, 8'h01);
         srcs(r, !e, !e, 12);
         srcs(r, !e, e, 12);
         if (f) srcs(r, e, e, 3);
         srcs(r, !e, e, 12);
         chk({31'h0, ifc.irq}, 32'h0);
         srcs(r, e, e, 12);
         chk({31'h0, ifc.irq}, 32'h1);
         axi_rd(TMRW_AXI_ADDR_STAT, 32'h0000_0001);
         brd(TMRW_ADDR_CMP_A, v[7:0]);
         brd(TMRW_ADDR_CMP_B, v[15:8]);
         bwr(TMRW_ADDR_MASK, 8'h00);
         chk({31'h0, ifc.irq}, 32'h0);
         bwr(TMRW_ADDR_MASK, 8'h01);
         bwr(TMRW_ADDR_FLAG, 8'h01);
         chk({31'h0, ifc.irq}, 32'h0);
      end
      $display("Capture done");
      report_and_stop();
   end
endmodule : test_timer0_wide_access_capture_ctrl

/* tmrw_cpu.sv */
// Processor end: AXI4-Lite slave turning word writes into byte bus cycles.
// Assumes software keeps byte order and interrupt masking around pairs.
`timescale 1ns/100ps
module tmrw_cpu
   import tmrw_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer bus
   tmrw_if.cpu bus
);
   // Byte command word: [15]=read, [13:8]=address, [7:0]=data.
   // Software issues pairs in order: high write first, low read first.
   logic aw_got_r, w_got_r;
   logic [31:0] awaddr_r, wdata_r;
   logic [1:0] wstrb_r;
   logic bvalid_r, rvalid_r, bad_w_r, bad_r_r;
   logic [31:0] rdata_r;
   logic [7:0] last_rd_r;
   logic pend_r;
   logic wr_r, rd_r;
   logic [5:0] addr_r;
   logic [7:0] bdata_r;

   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready = !w_got_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 32'h0000_0000;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 2'b00;
      end else if (aw_got_r && w_got_r) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One byte cycle per accepted write to the command register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         addr_r <= 6'h00;
         bdata_r <= 8'h00;
         bvalid_r <= 1'b0;
         bad_w_r <= 1'b0;
      end else begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) bvalid_r <= 1'b0;
         if (aw_got_r && w_got_r) begin
            bvalid_r <= 1'b1;
            // Command needs both low lanes; a partial word is refused
            bad_w_r <= (awaddr_r[7:0] != TMRW_AXI_ADDR_OFF[7:0]) || (wstrb_r != 2'b11);
            if (awaddr_r[7:0] == TMRW_AXI_ADDR_OFF[7:0] && wstrb_r == 2'b11) begin
               wr_r <= !wdata_r[15]; // RULE3 RULE10 RULE12
               rd_r <= wdata_r[15]; // RULE10
               addr_r <= wdata_r[13:8];
               bdata_r <= wdata_r[7:0];
            end
         end
      end
   end

   assign bus.wr = wr_r;
   assign bus.rd = rd_r;
   assign bus.addr = addr_r;
   assign bus.wdata = bdata_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bad_w_r ? 2'b10 : 2'b00;

   always_ff @(posedge aclk) begin
      if (!aresetn) pend_r <= 1'b0;
      else pend_r <= rd_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) last_rd_r <= 8'h00;
      else if (pend_r) last_rd_r <= bus.rdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read: status = {busy, irq}, data = last byte read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         bad_r_r <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         bad_r_r <= 1'b0;
         if (s_axi_araddr[7:0] == TMRW_AXI_ADDR_STAT[7:0])
            rdata_r <= {30'h0000_0000, (rd_r || pend_r), bus.irq};
         else if (s_axi_araddr[7:0] == TMRW_AXI_ADDR_RDATA[7:0]) rdata_r <= {24'h00_0000, last_rd_r};
         else if (s_axi_araddr[7:0] == TMRW_AXI_ADDR_OFF[7:0]) rdata_r <= 32'h0000_0000;
         else begin
            rdata_r <= 32'h0000_0000;
            bad_r_r <= 1'b1;
         end
      end else if (s_axi_rready) rvalid_r <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = bad_r_r ? 2'b10 : 2'b00;
endmodule : tmrw_cpu

/* tmrw_if.sv */
// Byte bus between the processor-side controller and the timer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tmrw_if (input wire logic aclk);
   logic [5:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic irq;
   modport dev (input addr, wdata, wr, rd, output rdata, irq);
   modport cpu (output addr, wdata, wr, rd, input rdata, irq);
endinterface : tmrw_if

/* tmrw_pkg.sv */
// Constants, types and register map of the wide-access capture timer.
// Assumes one system clock aclk and a synchronous active-low reset aresetn.
// Function
// [RULE1] Counter advances only on tick enable
// [RULE2] Width bit joins compare into sixteen bits
// [RULE3] Wide registers reached as two bytes
// [RULE4] Exactly one shared high-byte latch
// [RULE5] Only low-byte access moves sixteen bits
// [RULE6] Low write loads latch and byte together
// [RULE7] Low read copies high byte into latch
// [RULE8] Compare reads bypass the latch
// [RULE9] Sixteen-bit capture reads use the latch
// [RULE10] Write high first, read low first
// [RULE11] Main code blocks interrupts around pairs
// [RULE12] Latch holds across several low writes
// [RULE13] Capture-mode bit enables input capture
// [RULE14] Filter needs four equal samples
// [RULE15] Edge bit: zero falling, one rising
// [RULE16] Trigger copies counter, sets capture flag
// [RULE17] Route bit feeds comparator to capture
// [RULE18] Comparator capture interrupts only when enabled
// [RULE19] Control bits two and one read zero
// [RULE20] Width and capture override clear-on-match
// [RULE21] Clear-on-match tops counter at compare A
// [RULE22] Writing one clears capture flag
// [RULE23] Latch changes only on latch accesses
// [RULE24] Control fields reset to zero
package tmrw_pkg;
   localparam logic [5:0] TMRW_ADDR_CNT_L = 6'h12;
   localparam logic [5:0] TMRW_ADDR_CNT_H = 6'h14;
   localparam logic [5:0] TMRW_ADDR_CTRL = 6'h15;
   localparam logic [5:0] TMRW_ADDR_CMP_A = 6'h13;
   localparam logic [5:0] TMRW_ADDR_CMP_B = 6'h16;
   localparam logic [5:0] TMRW_ADDR_MASK = 6'h39;
   localparam logic [5:0] TMRW_ADDR_FLAG = 6'h38;
   localparam int TMRW_BIT_WIDTH = 7;
   localparam int TMRW_BIT_CAPEN = 6;
   localparam int TMRW_BIT_FILT = 5;
   localparam int TMRW_BIT_EDGE = 4;
   localparam int TMRW_BIT_ROUTE = 3;
   localparam int TMRW_BIT_CTC = 0;
   localparam int TMRW_BIT_CAPFLAG = 0;
   localparam int TMRW_BIT_CAPIE = 0;
   localparam logic [7:0] TMRW_CTRL_WMASK = 8'hF9;
   localparam logic [7:0] TMRW_CTRL_RESET = 8'h00;
   localparam int TMRW_FILT_SAMPLES = 4;
   localparam logic [7:0] TMRW_MAX8 = 8'hFF;
   localparam logic [15:0] TMRW_MAX16 = 16'hFFFF;
   localparam logic [31:0] TMRW_AXI_ADDR_OFF = 32'h0000_0000;
   localparam logic [31:0] TMRW_AXI_ADDR_STAT = 32'h0000_0004;
   localparam logic [31:0] TMRW_AXI_ADDR_RDATA = 32'h0000_0008;
   typedef enum logic [4:0] {
      TMRW_MODE_N8 = 5'b00001,
      TMRW_MODE_CTC8 = 5'b00010,
      TMRW_MODE_N16 = 5'b00100,
      TMRW_MODE_IC8 = 5'b01000,
      TMRW_MODE_IC16 = 5'b10000
   } tmrw_mode_e;
endpackage : tmrw_pkg

/* tmrw_props.sv */
// Checker on the byte bus between the processor end and the timer.
// Assumes one clock and the reset aresetn beside the bus.
`timescale 1ns/100ps
module tmrw_props
   import tmrw_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Byte bus
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] ctrl_r;
   logic [7:0] lat_r;
   logic [15:0] cmp_r;
   logic mask_r;
   logic lat_ok_r;
   logic cmp_ok_r;
   logic hw;
   logic hi_wr;
   assign hw = ctrl_r[TMRW_BIT_WIDTH];
   assign hi_wr = wr && (addr == TMRW_ADDR_CNT_H || addr == TMRW_ADDR_CMP_B);
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= 8'h00;
      end else if (wr && addr == TMRW_ADDR_CTRL) begin
         ctrl_r <= wdata & 8'hF9;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_r <= 1'h0;
      end else if (wr && addr == TMRW_ADDR_MASK) begin
         mask_r <= wdata[0];
      end
   end
   // Low reads refill the latch from state not seen here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lat_r <= 8'h00;
         lat_ok_r <= 1'h1;
      end else if (hi_wr) begin
         lat_r <= wdata;
         lat_ok_r <= hw;
      end else if (rd && (addr == TMRW_ADDR_CNT_L || addr == TMRW_ADDR_CMP_A)) begin
         lat_ok_r <= 1'h0;
      end
   end
   // Captures overwrite compare A, and B too when wide, so trust ends in capture mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_r <= 16'h0000;
         cmp_ok_r <= 1'h1;
      end else if (ctrl_r[TMRW_BIT_CAPEN]) begin
         cmp_ok_r <= 1'h0;
      end else if (wr && addr == TMRW_ADDR_CMP_A && hw) begin
         cmp_r <= {lat_r, wdata};
         cmp_ok_r <= lat_ok_r;
      end else if (hi_wr || wr && addr == TMRW_ADDR_CMP_A) begin
         cmp_ok_r <= 1'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_CTRL_RD: assert property (rd && addr == TMRW_ADDR_CTRL |=> rdata == ctrl_r)
      else $error("control readback wrong");
   AST_RESET_ZERO: assert property ($rose(aresetn) |-> rdata == 8'h00 && !irq)
      else $error("bus not quiet after reset");
   AST_CMP_LOW: assert property (rd && addr == TMRW_ADDR_CMP_A && hw && cmp_ok_r |=> rdata == cmp_r[7:0])
      else $error("compare low read wrong");
   AST_CMP_HIGH: assert property (rd && addr == TMRW_ADDR_CMP_B && hw && cmp_ok_r |=> rdata == cmp_r[15:8])
      else $error("compare high read wrong");
   AST_LATCH_RD: assert property (rd && addr == TMRW_ADDR_CNT_H && hw && lat_ok_r |=> rdata == lat_r)
      else $error("latch lost its value");
   AST_IRQ_MASK: assert property (irq |-> mask_r)
      else $error("irq while masked");
   AST_ONE_STROBE: assert property (!(wr && rd))
      else $error("read and write together");
   AST_WR_PULSE: assert property (wr |=> !wr)
      else $error("write strobe too long");
endmodule : tmrw_props

/* tmrw_timer.sv */
// Timer/counter with shared high-byte latch and input capture.
// Assumes one byte access a cycle from the processor end, same clock.
`timescale 1ns/100ps
module tmrw_timer
   import tmrw_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Processor bus
   tmrw_if.dev bus,
   // Timing and capture sources
   input wire logic timer_tick_enable,
   input wire logic capture_pin,
   input wire logic comparator_out
);
   logic [7:0] ctrl_r;
   logic [7:0] cnt_l_r, cnt_h_r;
   logic [7:0] cmp_a_r, cmp_b_r;
   logic [7:0] latch_r;
   logic [7:0] mask_r;
   logic capture_flag_r;
   logic [7:0] rdata_r;
   logic [1:0] src_s1_r, src_s2_r;
   logic [TMRW_FILT_SAMPLES-2:0] filt_hist_r;
   logic filt_out_r;
   logic edge_prev_r;
   tmrw_mode_e mode;
   logic wide, capen, cap_sync, cap_in, trig;
   logic [15:0] cnt16, cmp16;

   ////////////////////////////////////////////////////////////////////////
   assign wide = ctrl_r[TMRW_BIT_WIDTH]; // RULE2
   assign capen = ctrl_r[TMRW_BIT_CAPEN]; // RULE13
   assign cnt16 = {cnt_h_r, cnt_l_r};
   assign cmp16 = {cmp_b_r, cmp_a_r};

   always_comb begin
      // Width and capture outrank clear-on-match
      if (capen && wide) mode = TMRW_MODE_IC16; // RULE20
      else if (capen) mode = TMRW_MODE_IC8;
      else if (wide) mode = TMRW_MODE_N16;
      else if (ctrl_r[TMRW_BIT_CTC]) mode = TMRW_MODE_CTC8;
      else mode = TMRW_MODE_N8;
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture front end: sync, route, filter, edge
   // Both sources synced ahead of the mux, so no raw pin reaches logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_s1_r <= 2'b00;
         src_s2_r <= 2'b00;
      end else begin
         src_s1_r <= {comparator_out, capture_pin};
         src_s2_r <= src_s1_r;
      end
   end

   assign cap_sync = ctrl_r[TMRW_BIT_ROUTE] ? src_s2_r[1] : src_s2_r[0]; // RULE17

   // Window: last three samples plus the current one, four cycles of delay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt_hist_r <= '0;
         filt_out_r <= 1'b0;
      end else begin
         filt_hist_r <= {filt_hist_r[TMRW_FILT_SAMPLES-3:0], cap_sync};
         if ({filt_hist_r, cap_sync} == '1) filt_out_r <= 1'b1; // RULE14
         else if ({filt_hist_r, cap_sync} == '0) filt_out_r <= 1'b0; // RULE14
      end
   end

   assign cap_in = ctrl_r[TMRW_BIT_FILT] ? filt_out_r : cap_sync;

   always_ff @(posedge aclk) begin
      if (!aresetn) edge_prev_r <= 1'b0;
      else edge_prev_r <= cap_in;
   end

   // Edge bit zero picks falling, one picks rising
   assign trig = capen && (ctrl_r[TMRW_BIT_EDGE] ? (cap_in && !edge_prev_r)
                                                  : (!cap_in && edge_prev_r)); // RULE15

   ////////////////////////////////////////////////////////////////////////
   // Control, mask and flag registers
   always_ff @(posedge aclk) begin
      if (!aresetn) ctrl_r <= TMRW_CTRL_RESET; // RULE24
      else if (bus.wr && bus.addr == TMRW_ADDR_CTRL) ctrl_r <= bus.wdata & TMRW_CTRL_WMASK; // RULE19
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) mask_r <= 8'h00;
      else if (bus.wr && bus.addr == TMRW_ADDR_MASK) mask_r <= bus.wdata;
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) capture_flag_r <= 1'b0;
      else if (trig) capture_flag_r <= 1'b1; // RULE16
      else if (bus.wr && bus.addr == TMRW_ADDR_FLAG && bus.wdata[TMRW_BIT_CAPFLAG])
         capture_flag_r <= 1'b0; // RULE22
   end

   assign bus.irq = capture_flag_r && mask_r[TMRW_BIT_CAPIE]; // RULE18

   ////////////////////////////////////////////////////////////////////////
   // Shared latch: high writes and latch-using low reads only
   always_ff @(posedge aclk) begin
      if (!aresetn) latch_r <= 8'h00;
      else if (bus.wr && (bus.addr == TMRW_ADDR_CNT_H || (wide && bus.addr == TMRW_ADDR_CMP_B)))
         latch_r <= bus.wdata; // RULE4 RULE5 RULE23
      else if (bus.rd && wide && bus.addr == TMRW_ADDR_CNT_L) latch_r <= cnt_h_r; // RULE7
      else if (bus.rd && mode == TMRW_MODE_IC16 && bus.addr == TMRW_ADDR_CMP_A)
         latch_r <= cmp_b_r; // RULE9
   end

   // Counter; low write merges latch (RULE12: latch not consumed)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_l_r <= 8'h00;
         cnt_h_r <= 8'h00;
      end else if (bus.wr && bus.addr == TMRW_ADDR_CNT_L) begin
         cnt_l_r <= bus.wdata;
         if (wide) cnt_h_r <= latch_r; // RULE6 RULE12
      end else if (timer_tick_enable) begin // RULE1
         if (mode == TMRW_MODE_CTC8 && cnt_l_r == cmp_a_r) cnt_l_r <= 8'h00; // RULE21
         else if (wide) {cnt_h_r, cnt_l_r} <= (cnt16 == TMRW_MAX16) ? 16'h0000 : cnt16 + 16'h0001;
         else cnt_l_r <= (cnt_l_r == TMRW_MAX8) ? 8'h00 : cnt_l_r + 8'h01;
      end
   end

   // Compare A, and B too when wide, doubles as capture register in capture mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_a_r <= 8'h00;
         cmp_b_r <= 8'h00;
      end else if (trig) begin
         cmp_a_r <= cnt_l_r; // RULE16
         if (wide) cmp_b_r <= cnt_h_r;
      end else if (bus.wr && bus.addr == TMRW_ADDR_CMP_A) begin
         cmp_a_r <= bus.wdata;
         if (wide) cmp_b_r <= latch_r; // RULE2 RULE6 RULE12
      end else if (bus.wr && !wide && bus.addr == TMRW_ADDR_CMP_B) begin
         cmp_b_r <= bus.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, registered one cycle after rd
   always_ff @(posedge aclk) begin
      if (!aresetn) rdata_r <= 8'h00;
      else if (bus.rd) begin
         if (bus.addr == TMRW_ADDR_CTRL) rdata_r <= ctrl_r; // RULE19
         else if (bus.addr == TMRW_ADDR_CNT_L) rdata_r <= cnt_l_r;
         else if (bus.addr == TMRW_ADDR_CNT_H) rdata_r <= wide ? latch_r : cnt_h_r; // RULE3
         else if (bus.addr == TMRW_ADDR_CMP_A) rdata_r <= cmp_a_r;
         else if (bus.addr == TMRW_ADDR_CMP_B)
            rdata_r <= (mode == TMRW_MODE_IC16) ? latch_r : cmp_b_r; // RULE8 RULE9
         else if (bus.addr == TMRW_ADDR_MASK) rdata_r <= mask_r;
         else if (bus.addr == TMRW_ADDR_FLAG) rdata_r <= {7'h00, capture_flag_r};
         else rdata_r <= 8'h00;
      end
   end
   assign bus.rdata = rdata_r;
endmodule : tmrw_timer
